//--- logic/tmcs_pkg.sv
// Package of register layout, modes and timing constants for the timer control block
package tmcs_pkg;
    localparam int CNT_W = 24;
    localparam int ADDR_W = 4;
    // Register indices (word addresses on the plain port)
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_LOAD = 4'h1;
    localparam logic [3:0] ADDR_CMP = 4'h2;
    localparam logic [3:0] ADDR_COUNT = 4'h3;
    localparam logic [3:0] ADDR_PRESC = 4'h4;
    // Control field positions
    localparam int BIT_RUN = 0;
    localparam int BIT_OVF_IE = 1;
    localparam int BIT_CMP_IE = 2;
    localparam int BIT_MODE_LO = 4;
    localparam int BIT_INV = 8;
    localparam int BIT_DIR = 11;
    localparam int BIT_DIN = 12;
    localparam int BIT_DOUT = 13;
    localparam int BIT_PSEL = 15;
    localparam int BIT_OVF = 20;
    localparam int BIT_CMPF = 21;
    localparam logic [23:0] CTRL_WMASK = 24'h00a9f7;
    localparam logic [23:0] CTRL_RESET = 24'h000000;
    localparam logic [23:0] CNT_MAX = 24'hffffff;
    // Operating modes
    localparam logic [3:0] MODE_GPIO = 4'h0;
    localparam logic [3:0] MODE_PULSE = 4'h1;
    localparam logic [3:0] MODE_TOGGLE = 4'h2;
    localparam logic [3:0] MODE_EVENT = 4'h3;
    localparam logic [3:0] MODE_WIDTH = 4'h4;
    localparam logic [3:0] MODE_PERIOD = 4'h5;
    localparam logic [3:0] MODE_CAPTURE = 4'h6;
    localparam logic [3:0] MODE_PWM = 4'h7;
    localparam logic [3:0] MODE_WD_PULSE = 4'h9;
    localparam logic [3:0] MODE_WD_TOGGLE = 4'ha;
    // Internal source clock is the system clock divided by two
    localparam int CLK_HZ = 50000000;
    localparam int INT_DIV = 2;
    localparam logic [1:0] INT_DIV_LAST = 2'(INT_DIV - 1);
    typedef enum logic [2:0] {
        TMCS_IDLE = 3'b001,
        TMCS_ARMED = 3'b010,
        TMCS_COUNTING = 3'b100
    } tmcs_state_type;
endpackage

//--- logic/tmcs_pin_sync.sv
// Pin synchroniser with polarity applied and edge detection
`timescale 1ns/1ns
module tmcs_pin_sync (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic pin_in,
    input wire logic invert,
    output logic level,
    output logic rise
);
    logic stage1;
    logic stage2;
    logic prev;

    // Two flops before any logic reads the pin
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
        end
    end

    // Polarity-corrected level and its active edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            level <= 1'b0;
            prev <= 1'b0;
        end else begin
            level <= stage2 ^ invert;
            prev <= level;
        end
    end

    // Falling pin edge counts when inverted, since level is already flipped
    assign rise = level & ~prev;
endmodule

//--- logic/tmcs_timer.sv
// Timer control, status, counter and pin logic for one 24-bit timer
`timescale 1ns/1ns
module tmcs_timer
    import tmcs_pkg::*;
#(
    parameter int CNT_WIDTH = tmcs_pkg::CNT_W
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic soft_reset,
    input wire logic [tmcs_pkg::ADDR_W-1:0] bus_addr,
    input wire logic [23:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [23:0] bus_rdata,
    input wire logic prescale_tick,
    input wire logic other_timers_active,
    input wire logic ovf_irq_ack,
    input wire logic cmp_irq_ack,
    input wire logic timer_io_pin_in,
    output logic timer_io_pin_out,
    output logic timer_io_pin_oe,
    output logic timer_active,
    output logic ovf_irq,
    output logic cmp_irq
);
    import tmcs_pkg::*;

    // Refuse widths at elaboration, since the datapath is fixed at 24 bits
    if (CNT_WIDTH != 24) begin : g_width_check
        $error("tmcs_timer supports only a 24-bit counter");
    end

    logic [23:0] ctrl;
    logic [23:0] load_value;
    logic [23:0] compare_value;
    logic [23:0] count_value;
    logic overflow_flag;
    logic compare_flag;
    logic out_level;
    logic pin_level;
    logic pin_edge;
    logic int_tick;
    logic [1:0] div_cnt;
    logic event_tick;
    logic ovf_event;
    logic cmp_event;
    logic [23:0] next_count;
    tmcs_state_type state;

    wire timer_run_enable = ctrl[BIT_RUN];
    wire overflow_irq_enable = ctrl[BIT_OVF_IE];
    wire compare_irq_enable = ctrl[BIT_CMP_IE];
    wire [3:0] mode_select = ctrl[BIT_MODE_LO+3:BIT_MODE_LO];
    wire polarity_invert = ctrl[BIT_INV];
    wire gpio_dir = ctrl[BIT_DIR];
    wire gpio_dout = ctrl[BIT_DOUT];
    wire prescale_clock_select = ctrl[BIT_PSEL];
    wire gpio_mode = (mode_select == MODE_GPIO);

    ////////////////////////////////////////////////////////////////////////////
    // Pin input path

    tmcs_pin_sync u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin_in(timer_io_pin_in),
        .invert(polarity_invert),
        .level(pin_level),
        .rise(pin_edge)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode

    logic pin_is_output;
    logic pin_is_input;
    logic compare_mode;
    always_comb begin
        pin_is_output = 1'b0;
        pin_is_input = 1'b0;
        compare_mode = 1'b0;
        case (mode_select)
            MODE_GPIO: begin
                compare_mode = 1'b1;
            end
            MODE_PULSE, MODE_TOGGLE, MODE_PWM, MODE_WD_PULSE, MODE_WD_TOGGLE: begin
                pin_is_output = 1'b1;
                compare_mode = 1'b1;
            end
            MODE_EVENT, MODE_WIDTH, MODE_PERIOD, MODE_CAPTURE: begin
                pin_is_input = 1'b1;
            end
            default: begin
                pin_is_output = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counting source: internal half rate, pin edges or the prescaler

    // Divider gives the internal source as a one-cycle enable
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= 2'h0;
        end else if (div_cnt == INT_DIV_LAST) begin
            div_cnt <= 2'h0;
        end else begin
            div_cnt <= div_cnt + 2'h1;
        end
    end
    assign int_tick = (div_cnt == INT_DIV_LAST);

    always_comb begin
        if (prescale_clock_select) begin
            event_tick = prescale_tick;
        end else if (mode_select == MODE_EVENT) begin
            event_tick = pin_edge;
        end else begin
            event_tick = int_tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter sequencing

    wire ctrl_write = bus_wr && (bus_addr == ADDR_CTRL);
    wire run_rise = ctrl_write && bus_wdata[BIT_RUN] && !timer_run_enable;

    // First event after enable loads the counter from the load value
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= TMCS_IDLE;
        end else if (soft_reset || !timer_run_enable) begin
            state <= TMCS_IDLE;
        end else begin
            case (state)
                TMCS_IDLE: state <= TMCS_ARMED;
                TMCS_ARMED: if (event_tick) state <= TMCS_COUNTING;
                TMCS_COUNTING: state <= TMCS_COUNTING;
                default: state <= TMCS_IDLE;
            endcase
        end
    end

    always_comb begin
        next_count = count_value + 24'h000001;
        ovf_event = 1'b0;
        cmp_event = 1'b0;
        if (state == TMCS_ARMED) begin
            next_count = load_value;
        end else begin
            ovf_event = (count_value == CNT_MAX);
        end
        cmp_event = compare_mode && (next_count == compare_value);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count_value <= 24'h000000;
        end else if (soft_reset || run_rise) begin
            count_value <= 24'h000000;
        end else if (timer_run_enable && state != TMCS_IDLE && event_tick) begin
            count_value <= next_count;
        end
    end

    wire counted = timer_run_enable && state != TMCS_IDLE && event_tick;

    ////////////////////////////////////////////////////////////////////////////
    // Control register

    // Only writable bits are stored, so reserved bits stay zero
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= CTRL_RESET;
        end else if (soft_reset) begin
            ctrl <= CTRL_RESET;
        end else if (ctrl_write) begin
            ctrl <= bus_wdata & CTRL_WMASK;
            if (!gpio_mode || !(bus_wdata[BIT_MODE_LO+3:BIT_MODE_LO] == MODE_GPIO)) begin
                ctrl[BIT_DOUT] <= ctrl[BIT_DOUT];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            load_value <= 24'h000000;
            compare_value <= 24'h000000;
        end else if (soft_reset) begin
            load_value <= 24'h000000;
            compare_value <= 24'h000000;
        end else if (bus_wr) begin
            if (bus_addr == ADDR_LOAD) load_value <= bus_wdata;
            if (bus_addr == ADDR_CMP) compare_value <= bus_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky flags: set wins over a clear in the same cycle

    wire ovf_clr = (ctrl_write && bus_wdata[BIT_OVF]) || ovf_irq_ack;
    wire cmp_clr = (ctrl_write && bus_wdata[BIT_CMPF]) || cmp_irq_ack;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            overflow_flag <= 1'b0;
            compare_flag <= 1'b0;
        end else if (soft_reset) begin
            overflow_flag <= 1'b0;
            compare_flag <= 1'b0;
        end else begin
            overflow_flag <= (counted && ovf_event) || (overflow_flag && !ovf_clr);
            compare_flag <= (counted && cmp_event) || (compare_flag && !cmp_clr);
        end
    end

    assign ovf_irq = overflow_flag && overflow_irq_enable;
    assign cmp_irq = compare_flag && compare_irq_enable;

    ////////////////////////////////////////////////////////////////////////////
    // Pin output and drive enable

    // Toggle on compare in toggle modes, pulse for one event otherwise
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            out_level <= 1'b0;
        end else if (!timer_run_enable) begin
            out_level <= 1'b0;
        end else if (counted) begin
            if (mode_select == MODE_TOGGLE || mode_select == MODE_WD_TOGGLE) begin
                out_level <= out_level ^ cmp_event;
            end else begin
                out_level <= cmp_event;
            end
        end
    end

    assign timer_active = timer_run_enable || gpio_mode;
    always_comb begin
        if (gpio_mode) begin
            timer_io_pin_out = gpio_dout ^ polarity_invert;
            timer_io_pin_oe = gpio_dir;
        end else begin
            timer_io_pin_out = out_level ^ polarity_invert;
            timer_io_pin_oe = pin_is_output && (timer_active || other_timers_active);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register read port, data one cycle after the strobe

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bus_rdata <= 24'h000000;
        end else if (bus_rd) begin
            case (bus_addr)
                ADDR_CTRL: begin
                    bus_rdata <= ctrl;
                    bus_rdata[BIT_DIN] <= gpio_mode ? pin_level : 1'b0;
                    bus_rdata[BIT_OVF] <= overflow_flag;
                    bus_rdata[BIT_CMPF] <= compare_flag;
                end
                ADDR_CMP: bus_rdata <= compare_value;
                ADDR_COUNT: bus_rdata <= count_value;
                default: bus_rdata <= 24'h000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    a_reset_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
        soft_reset |=> ctrl == CTRL_RESET) else $error("soft reset left control bits");
    a_run_clears_cnt: assert property (@(posedge clk_sys) disable iff (!rst_n)
        run_rise && !soft_reset |=> count_value == 24'h000000) else $error("counter not cleared");
    // Soft reset may clear a stopped counter, so it is left out here
    a_stop_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !timer_run_enable && !run_rise && !soft_reset |=> $stable(count_value))
        else $error("counter moved while off");
    a_ovf_wrap: assert property (@(posedge clk_sys) disable iff (!rst_n)
        counted && state == TMCS_COUNTING && count_value == CNT_MAX && !soft_reset && !run_rise
        |=> count_value == 24'h000000 && overflow_flag) else $error("overflow not flagged");
    a_ovf_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ovf_irq |-> overflow_flag && ctrl[BIT_OVF_IE]) else $error("overflow irq without cause");
    a_cmp_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cmp_irq |-> compare_flag && ctrl[BIT_CMP_IE]) else $error("compare irq without cause");
    a_load_first: assert property (@(posedge clk_sys) disable iff (!rst_n)
        counted && state == TMCS_ARMED && !soft_reset |=> count_value == $past(load_value))
        else $error("load value not taken");
    a_gpio_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
        mode_select != MODE_GPIO && !pin_is_output |-> !timer_io_pin_oe)
        else $error("pin driven in input mode");
    a_float_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !gpio_mode && !timer_run_enable && !other_timers_active |-> !timer_io_pin_oe)
        else $error("pin driven while idle");
    a_gpio_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
        gpio_mode && gpio_dir |-> timer_io_pin_out == (ctrl[BIT_DOUT] ^ ctrl[BIT_INV]))
        else $error("gpio output wrong");
    c_overflow: cover property (@(posedge clk_sys) disable iff (!rst_n) counted && ovf_event);
    c_compare: cover property (@(posedge clk_sys) disable iff (!rst_n) counted && cmp_event);
    c_event_mode: cover property (@(posedge clk_sys) disable iff (!rst_n) counted && mode_select == MODE_EVENT);
endmodule

//--- sim/tmcs_pin_model.sv
// Far-side model of the timer pin: an external source that can drive, or a load with a pull-down
`timescale 1ns/1ns
module tmcs_pin_model (
    input wire logic drv_en,
    input wire logic drv_val,
    input wire logic pin_out,
    input wire logic pin_oe,
    output logic pin_level
);
    ////////////////////////////////////////////////////////////////////////////
    // Wire resolution: the block wins while it drives, then the external source,
    // otherwise the pull-down holds the floating pin low so no unknown leaks in
    always_comb begin
        if (pin_oe) begin
            pin_level = pin_out;
        end else if (drv_en) begin
            pin_level = drv_val; // edges come from the bench slower than a quarter of clk_sys
        end else begin
            pin_level = 1'b0; // released pin settles to the pull-down level
        end
    end
endmodule

//--- sim/testbench.sv
// Self-checking bench for the timer control and status block
`timescale 1ns/1ns
module testbench;
    import tmcs_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic soft_reset = 1'b0;
    logic [3:0] bus_addr = 4'h0;
    logic [23:0] bus_wdata = 24'h000000;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [23:0] bus_rdata;
    logic prescale_tick = 1'b0;
    logic other_act = 1'b0;
    logic ovf_ack = 1'b0;
    logic cmp_ack = 1'b0;
    logic pin_level, pin_out, pin_oe, timer_active, ovf_irq, cmp_irq;
    logic drv_en = 1'b0;
    logic drv_val = 1'b0;
    logic [23:0] rv;
    int bad_count = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [3:0] modes [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'ha};

    always #10 clk_sys = ~clk_sys;

    tmcs_timer dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .soft_reset(soft_reset), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .prescale_tick(prescale_tick), .other_timers_active(other_act), .ovf_irq_ack(ovf_ack),
        .cmp_irq_ack(cmp_ack), .timer_io_pin_in(pin_level), .timer_io_pin_out(pin_out),
        .timer_io_pin_oe(pin_oe), .timer_active(timer_active), .ovf_irq(ovf_irq), .cmp_irq(cmp_irq));

    tmcs_pin_model pin_u (.drv_en(drv_en), .drv_val(drv_val), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_level(pin_level));

    ////////////////////////////////////////////////////////////////////////////
    // Shared helpers: comparison, bus cycles, pulses
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [23:0] d);
        @(posedge clk_sys);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
    endtask

    // Read data appear in the cycle after the strobe and hold until the next read, so sample just inside it
    task automatic rd(input logic [3:0] a, output logic [23:0] d);
        @(posedge clk_sys);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        #1 d = bus_rdata;
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // One prescaler event, then time for the flags to land
    task automatic tick();
        @(posedge clk_sys);
        prescale_tick <= 1'b1;
        @(posedge clk_sys);
        prescale_tick <= 1'b0;
        wait_clk(2);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_gpio();
        wr(ADDR_CTRL, 24'hffff0e);
        wait_clk(4);
        chk({pin_oe, pin_out}, 2'b10);
        rd(ADDR_CTRL, rv);
        chk(rv, 24'h00b906);
        wr(ADDR_CTRL, 24'h00a806);
        wait_clk(4);
        chk({pin_oe, pin_out}, 2'b11);
        wr(ADDR_CTRL, 24'h000100);
        drv_en <= 1'b1;
        drv_val <= 1'b1;
        wait_clk(4);
        chk(pin_oe, 1'b0);
        rd(ADDR_CTRL, rv);
        chk(rv, 24'h000100);
        drv_val <= 1'b0;
        wait_clk(4);
        rd(ADDR_CTRL, rv);
        chk(rv, 24'h001100);
        drv_en <= 1'b0;
        rd(ADDR_LOAD, rv);
        chk(rv, 24'h000000);
        rd(ADDR_PRESC, rv);
        chk(rv, 24'h000000);
    endtask

    task automatic t_modes();
        logic exp_oe;
        wr(ADDR_CTRL, 24'h000010);
        wait_clk(2);
        chk(pin_oe, 1'b0);
        other_act <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            wr(ADDR_CTRL, {16'h0000, modes[i], 4'h0});
            wait_clk(2);
            exp_oe = modes[i] inside {4'h1, 4'h2, 4'h7, 4'h9, 4'ha};
            chk(pin_oe, exp_oe);
            chk(timer_active, modes[i] == 4'h0);
            rd(ADDR_CTRL, rv);
            chk(rv, {16'h0000, modes[i], 4'h0});
        end
        wr(ADDR_CTRL, 24'h002010);
        rd(ADDR_CTRL, rv);
        chk(rv, 24'h000010);
        other_act <= 1'b0;
    endtask

    task automatic t_compare();
        wr(ADDR_CTRL, 24'h008004);
        wr(ADDR_LOAD, 24'h000005);
        wr(ADDR_CMP, 24'h000009);
        wr(ADDR_CTRL, 24'h008005);
        wait_clk(3);
        for (int i = 1; i <= 5; i++) begin
            tick();
            chk(cmp_irq, i == 5);
        end
        rd(ADDR_COUNT, rv);
        chk(rv, 24'h000009);
        @(posedge clk_sys);
        cmp_ack <= 1'b1;
        @(posedge clk_sys);
        cmp_ack <= 1'b0;
        wait_clk(2);
        chk(cmp_irq, 1'b0);
        rd(ADDR_CTRL, rv);
        chk(rv, 24'h008005);
    endtask

    task automatic t_overflow();
        wr(ADDR_CTRL, 24'h008000);
        wr(ADDR_LOAD, 24'hfffffe);
        wr(ADDR_CTRL, 24'h008003);
        wait_clk(3);
        for (int i = 1; i <= 3; i++) begin
            tick();
            chk(ovf_irq, i == 3);
        end
        rd(ADDR_COUNT, rv);
        chk(rv, 24'h000000);
        wr(ADDR_CTRL, 24'h008001);
        wait_clk(1);
        chk(ovf_irq, 1'b0);
        rd(ADDR_CTRL, rv);
        chk(rv, 24'h108001);
        wr(ADDR_CTRL, 24'h108003);
        wait_clk(1);
        chk(ovf_irq, 1'b0);
        rd(ADDR_CTRL, rv);
        chk(rv, 24'h008003);
        tick();
        tick();
        wr(ADDR_CTRL, 24'h008000);
        tick();
        tick();
        rd(ADDR_COUNT, rv);
        chk(rv, 24'h000002);
        wr(ADDR_CTRL, 24'h008001);
        rd(ADDR_COUNT, rv);
        chk(rv, 24'h000000);
        repeat (3) tick();
        rd(ADDR_CTRL, rv);
        chk(rv, 24'h108001);
        @(posedge clk_sys);
        ovf_ack <= 1'b1;
        @(posedge clk_sys);
        ovf_ack <= 1'b0;
        rd(ADDR_CTRL, rv);
        chk(rv, 24'h008001);
    endtask

    task automatic t_soft_reset();
        @(posedge clk_sys);
        soft_reset <= 1'b1;
        @(posedge clk_sys);
        soft_reset <= 1'b0;
        rd(ADDR_CTRL, rv);
        chk(rv, 24'h000000);
        // Hardware reset in mid-run, with the pin driven and the timer armed but given no prescaler ticks
        wr(ADDR_CTRL, 24'h008117);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(ADDR_CTRL, rv);
        chk(rv, 24'h000000);
        chk({pin_oe, ovf_irq, cmp_irq}, 3'b000);
    endtask

    // External events at one eighth of clk_sys, well under the quarter limit
    task automatic t_event();
        drv_en <= 1'b1;
        drv_val <= 1'b0;
        wr(ADDR_CTRL, 24'h000031); // mode field set together with the start from a stopped timer
        wait_clk(3);
        chk(pin_oe, 1'b0);
        repeat (5) begin
            drv_val <= 1'b1;
            wait_clk(4);
            drv_val <= 1'b0;
            wait_clk(4);
        end
        rd(ADDR_COUNT, rv);
        chk(rv, 24'h000004);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Verdict and hang guard
    task automatic complete_run();
        if (bad_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            $display("[FAIL] %0t run did not finish", $time);
            complete_run();
        end
    end

    initial begin
        wait_clk(12);
        rst_n <= 1'b1;
        rd(ADDR_CTRL, rv);
        chk(rv, 24'h000000);
        chk({pin_oe, ovf_irq, cmp_irq}, 3'b000);
        t_gpio();
        t_modes();
        t_compare();
        t_overflow();
        t_soft_reset();
        t_event();
        complete_run();
    end
endmodule
